// ### hw/serial_char_rx.v
// Two-port character receive block with shared buffer bytes, events and station address
// Summary of operation
// - In free-form mode each received character raises one receive event.
// - The character is written to the shared buffer in the same edge that raises the event.
// - With parity enabled a parity error sets bit 0 of the status byte.
// - All other status bits are reserved and read zero.
// - Port 0 characters raise event 8 and fill both shared bytes.
// - Port 1 characters raise event 25 and fill both shared bytes.
// - Get-address returns the selected port's current station address.
// - Set-address changes the port address without storing it persistently.
// - After reset each port returns to its configured station address.
// - Bad indirect address gives 0006, refused set gives 0004; enable output cleared.
// - With parity disabled the parity error bit is never set.
`include "serial_char_rx_map.vh"
module serial_char_rx #(
    parameter       BAUD_DIV   = `BAUD_DIV_DEFAULT,
    parameter [7:0] CFG_ADDR0  = 8'h02,
    parameter [7:0] CFG_ADDR1  = 8'h03
) (
    // Clock and reset
    input  wire        ref_clk,
    input  wire        nrst,
    // Avalon-MM slave
    input  wire [5:0]  avs_address,
    input  wire        avs_read,
    input  wire        avs_write,
    input  wire [31:0] avs_writedata,
    input  wire [3:0]  avs_byteenable,
    output reg  [31:0] avs_readdata,
    output reg         avs_waitrequest,
    // Serial lines
    input  wire        rx0_pin,
    input  wire        rx1_pin,
    // Interrupt
    output reg         irq
);
    reg  [7:0]  rx_char_buffer;
    reg  [7:0]  rx_parity_status;
    reg  [1:0]  irq_status;
    reg  [1:0]  irq_enable;
    reg  [7:0]  port_config;
    reg  [7:0]  station_addr0;
    reg  [7:0]  station_addr1;
    reg  [31:0] addr_result;
    reg  [7:0]  last_event;
    reg         pend1;
    reg  [7:0]  pend1_char;
    reg         pend1_perr;
    reg         acked;
    reg  [31:0] next_readdata;
    wire        v0;
    wire        v1;
    wire [7:0]  d0;
    wire [7:0]  d1;
    wire        e0;
    wire        e1;
    wire        req = (avs_read | avs_write) & ~acked;
    // A write lands only at the edge where waitrequest is seen low
    wire        wr  = avs_write & acked;
    wire        free0 = port_config[`BIT_CFG_FREEFORM0];
    wire        free1 = port_config[`BIT_CFG_FREEFORM1];
    wire        take0 = v0 & free0;
    // Port 1 waits one cycle when both finish together so neither event is lost
    wire        take1 = ~take0 & (pend1 | (v1 & free1));
    wire [7:0]  c1 = pend1 ? pend1_char : d1;
    wire        p1 = pend1 ? pend1_perr : e1;
    wire [1:0]  clr = (wr && avs_address == `OFS_IRQ_CLEAR && avs_byteenable[0]) ? avs_writedata[1:0] : 2'h0;

    function [7:0] lane0;
        input [31:0] data;
        input [7:0]  old;
        input [3:0]  be;
        begin
            lane0 = be[0] ? data[7:0] : old;
        end
    endfunction

    serial_rx_port #(.BAUD_DIV(BAUD_DIV)) u_port0 (
        .ref_clk         (ref_clk),
        .nrst            (nrst),
        .rx_pin          (rx0_pin),
        .parity_en       (port_config[`BIT_CFG_PARITY_EN0]),
        .parity_odd      (port_config[`BIT_CFG_PARITY_ODD0]),
        .char_valid      (v0),
        .char_data       (d0),
        .char_parity_err (e0)
    );
    serial_rx_port #(.BAUD_DIV(BAUD_DIV)) u_port1 (
        .ref_clk         (ref_clk),
        .nrst            (nrst),
        .rx_pin          (rx1_pin),
        .parity_en       (port_config[`BIT_CFG_PARITY_EN1]),
        .parity_odd      (port_config[`BIT_CFG_PARITY_ODD1]),
        .char_valid      (v1),
        .char_data       (d1),
        .char_parity_err (e1)
    );

    // Shared bytes, event bits and irq all load in the same edge
    always @(posedge ref_clk) begin
        if (!nrst) begin
            rx_char_buffer   <= 8'h00;
            rx_parity_status <= 8'h00;
            last_event       <= 8'h00;
            pend1            <= 1'b0;
            pend1_char       <= 8'h00;
            pend1_perr       <= 1'b0;
        end else begin
            if (take0) begin
                rx_char_buffer   <= d0;
                rx_parity_status <= {7'h00, e0};
                last_event       <= `EVENT_PORT0;
            end else if (take1) begin
                rx_char_buffer   <= c1;
                rx_parity_status <= {7'h00, p1};
                last_event       <= `EVENT_PORT1;
            end
            if (take1)
                pend1 <= 1'b0;
            else if (v1 & free1 & take0) begin
                pend1      <= 1'b1;
                pend1_char <= d1;
                pend1_perr <= e1;
            end
        end
    end

    // Sticky status: a new event wins over a clear in the same cycle
    always @(posedge ref_clk) begin
        if (!nrst) begin
            irq_status <= 2'h0;
            irq        <= 1'b0;
        end else begin
            irq_status <= (irq_status & ~clr) | {take1, take0};
            irq        <= |(((irq_status & ~clr) | {take1, take0}) & irq_enable);
        end
    end

    // Station addresses live only in flops, so reset restores configured values
    always @(posedge ref_clk) begin
        if (!nrst) begin
            station_addr0 <= CFG_ADDR0;
            station_addr1 <= CFG_ADDR1;
            addr_result   <= 32'h0000_0000;
            irq_enable    <= `RST_IRQ_ENABLE;
            port_config   <= `RST_PORT_CONFIG;
        end else if (wr) begin
            if (avs_address == `OFS_IRQ_ENABLE && avs_byteenable[0])
                irq_enable <= avs_writedata[1:0];
            if (avs_address == `OFS_PORT_CONFIG)
                port_config <= lane0(avs_writedata, port_config, avs_byteenable);
            if (avs_address == `OFS_ADDR_CMD && avs_byteenable[1:0] == 2'h3) begin
                if (avs_writedata[`BIT_CMD_BADADDR])
                    addr_result <= {`ERR_INDIRECT_ADDR, 16'h0000};
                else if (avs_writedata[`BIT_CMD_SET] && port_config[`BIT_CFG_SPA_LOCK])
                    addr_result <= {`ERR_SET_ADDR_DENIED, 16'h0000};
                else if (avs_writedata[`BIT_CMD_SET]) begin
                    if (avs_writedata[`BIT_CMD_PORT])
                        station_addr1 <= avs_writedata[7:0];
                    else
                        station_addr0 <= avs_writedata[7:0];
                    addr_result <= {`ERR_NONE, 7'h00, 1'b1, avs_writedata[7:0]};
                end else
                    addr_result <= {`ERR_NONE, 7'h00, 1'b1,
                                    avs_writedata[`BIT_CMD_PORT] ? station_addr1 : station_addr0};
            end
        end
    end

    always @* begin
        case (avs_address)
            `OFS_RX_CHAR_BUFFER:   next_readdata = {24'h00_0000, rx_char_buffer};
            `OFS_RX_PARITY_STATUS: next_readdata = {24'h00_0000, rx_parity_status};
            `OFS_IRQ_STATUS:       next_readdata = {30'h0000_0000, irq_status};
            `OFS_IRQ_ENABLE:       next_readdata = {30'h0000_0000, irq_enable};
            `OFS_PORT_CONFIG:      next_readdata = {24'h00_0000, port_config};
            `OFS_ADDR_RESULT:      next_readdata = addr_result;
            `OFS_LAST_EVENT:       next_readdata = {24'h00_0000, last_event};
            default:               next_readdata = 32'h0000_0000;
        endcase
    end

    // One wait cycle per access; data registered with the ack
    always @(posedge ref_clk) begin
        if (!nrst) begin
            acked           <= 1'b0;
            avs_waitrequest <= 1'b1;
            avs_readdata    <= 32'h0000_0000;
        end else begin
            acked           <= req;
            avs_waitrequest <= ~req;
            if (avs_read & ~acked)
                avs_readdata <= next_readdata;
        end
    end
endmodule

// ### hw/serial_char_rx_map.vh
// Register offsets, field positions, reset values and codes of the character receive block
`ifndef SERIAL_CHAR_RX_MAP_VH
`define SERIAL_CHAR_RX_MAP_VH
`define OFS_RX_CHAR_BUFFER    6'h00
`define OFS_RX_PARITY_STATUS  6'h04
`define OFS_IRQ_STATUS        6'h08
`define OFS_IRQ_CLEAR         6'h0C
`define OFS_IRQ_ENABLE        6'h10
`define OFS_PORT_CONFIG       6'h14
`define OFS_ADDR_CMD          6'h18
`define OFS_ADDR_RESULT       6'h1C
`define OFS_LAST_EVENT        6'h20
`define BIT_PARITY_ERROR      0
`define BIT_CFG_FREEFORM0     0
`define BIT_CFG_FREEFORM1     1
`define BIT_CFG_PARITY_EN0    2
`define BIT_CFG_PARITY_EN1    3
`define BIT_CFG_PARITY_ODD0   4
`define BIT_CFG_PARITY_ODD1   5
`define BIT_CFG_SPA_LOCK      6
`define BIT_CMD_SET           8
`define BIT_CMD_PORT          9
`define BIT_CMD_BADADDR       10
`define BIT_RES_ENABLE_OUT    8
`define BIT_RES_ERR_LSB       16
`define RST_PORT_CONFIG       8'h03
`define RST_IRQ_ENABLE        2'h0
`define EVENT_PORT0           8'h08
`define EVENT_PORT1           8'h19
`define ERR_NONE              16'h0000
`define ERR_INDIRECT_ADDR     16'h0006
`define ERR_SET_ADDR_DENIED   16'h0004
`define BAUD_DIV_DEFAULT      16'h043D
`endif

// ### hw/serial_rx_port.v
// One serial receive port: pin synchroniser, 8-bit character with optional parity
`include "serial_char_rx_map.vh"
module serial_rx_port #(
    parameter BAUD_DIV = `BAUD_DIV_DEFAULT
) (
    // Clock and reset
    input  wire       ref_clk,
    input  wire       nrst,
    // Line and setup
    input  wire       rx_pin,
    input  wire       parity_en,
    input  wire       parity_odd,
    // Received character
    output reg        char_valid,
    output reg  [7:0] char_data,
    output reg        char_parity_err
);
    localparam ST_IDLE = 2'd0;
    localparam ST_DATA = 2'd1;
    localparam ST_PAR  = 2'd2;
    localparam ST_STOP = 2'd3;
    reg [2:0]  sync;
    reg        line;
    reg [1:0]  state;
    reg [15:0] cnt;
    reg [2:0]  bit_idx;
    reg [7:0]  shift;
    reg        par_bit;
    wire       tick = (cnt == 16'h0000);
    // Reload one short: the zero count is a cycle of its own
    localparam [31:0] BIT_FULL   = BAUD_DIV - 1;
    localparam [31:0] START_FULL = BAUD_DIV + (BAUD_DIV >> 1) - 1;
    localparam [15:0] DIV_BIT    = BIT_FULL[15:0];
    localparam [15:0] DIV_START  = START_FULL[15:0];
    // Line level changes only when the last two stages agree
    always @(posedge ref_clk) begin
        if (!nrst) begin
            sync <= 3'h7;
            line <= 1'b1;
        end else begin
            sync <= {sync[1:0], rx_pin};
            if (sync[1] == sync[2])
                line <= sync[2];
        end
    end
    always @(posedge ref_clk) begin
        if (!nrst) begin
            state           <= ST_IDLE;
            cnt             <= 16'h0000;
            bit_idx         <= 3'h0;
            shift           <= 8'h00;
            par_bit         <= 1'b0;
            char_valid      <= 1'b0;
            char_data       <= 8'h00;
            char_parity_err <= 1'b0;
        end else begin
            char_valid <= 1'b0;
            if (!tick)
                cnt <= cnt - 16'h0001;
            case (state)
                ST_IDLE: if (!line) begin
                    cnt   <= DIV_START;
                    state <= ST_DATA;
                    bit_idx <= 3'h0;
                end
                ST_DATA: if (tick) begin
                    shift <= {line, shift[7:1]};
                    cnt   <= DIV_BIT;
                    bit_idx <= bit_idx + 3'h1;
                    if (bit_idx == 3'h7)
                        state <= parity_en ? ST_PAR : ST_STOP;
                end
                ST_PAR: if (tick) begin
                    par_bit <= line;
                    cnt     <= DIV_BIT;
                    state   <= ST_STOP;
                end
                ST_STOP: if (tick) begin
                    char_valid <= 1'b1;
                    char_data  <= shift;
                    // Flag stays clear whenever parity is off
                    char_parity_err <= parity_en & ((^shift ^ par_bit) != parity_odd);
                    state <= ST_IDLE;
                end
                default: state <= ST_IDLE;
            endcase
        end
    end
endmodule

// ### verification/serial_char_rx_checker.sv
// Port-level checks of the two-port character receive block
`include "serial_char_rx_map.vh"
module serial_char_rx_checker (
    // Clock, reset and bus
    input wire        ref_clk,
    input wire        nrst,
    input wire [5:0]  avs_address,
    input wire        avs_read,
    input wire        avs_write,
    input wire [31:0] avs_writedata,
    input wire [3:0]  avs_byteenable,
    input wire [31:0] avs_readdata,
    input wire        avs_waitrequest,
    // Lines and interrupt
    input wire        rx0_pin,
    input wire        rx1_pin,
    input wire        irq
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!nrst);
    wire       rd = avs_read && !avs_waitrequest;
    wire [5:0] a  = avs_address;
    a_reset_idle: assert property (disable iff (1'b0) !nrst |=> avs_waitrequest && !irq && avs_readdata == 0)
        else $error("bus or irq not idle after reset");
    a_ack_single: assert property (!avs_waitrequest |=> avs_waitrequest)
        else $error("ack longer than one cycle");
    a_ack_bounded: assert property ((avs_read || avs_write) && avs_waitrequest |-> ##[1:4] !avs_waitrequest)
        else $error("access not answered");
    a_status_reserved: assert property (rd && a == `OFS_RX_PARITY_STATUS |-> avs_readdata[31:1] == 0)
        else $error("reserved status bits set");
    a_char_byte: assert property (rd && a == `OFS_RX_CHAR_BUFFER |-> avs_readdata[31:8] == 0)
        else $error("character word upper bits set");
    a_event_code: assert property (rd && a == `OFS_LAST_EVENT |-> avs_readdata inside {0, 8, 25})
        else $error("bad event number");
    a_err_codes: assert property (rd && a == `OFS_ADDR_RESULT && avs_readdata[31:16] != 0
        |-> !avs_readdata[8] && avs_readdata[31:16] inside {16'h0006, 16'h0004})
        else $error("bad address error result");
    a_unmapped_zero: assert property (rd && a > `OFS_LAST_EVENT |-> avs_readdata == 0)
        else $error("unmapped read not zero");
    a_mask_irq: assert property (avs_write && !avs_waitrequest && a == `OFS_IRQ_ENABLE && avs_byteenable[0]
        && avs_writedata[1:0] == 0 |-> ##2 !irq [*2])
        else $error("irq high while masked");
    cover property ($rose(irq));
    cover property (rd && a == `OFS_LAST_EVENT && avs_readdata == 25);
    cover property (rd && a == `OFS_IRQ_STATUS && avs_readdata == 3);
    cover property (rd && a == `OFS_ADDR_RESULT && avs_readdata[31:16] == 16'h0004);
endmodule
bind serial_char_rx serial_char_rx_checker u_chk (.ref_clk(ref_clk), .nrst(nrst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .rx0_pin(rx0_pin), .rx1_pin(rx1_pin), .irq(irq));

// ### verification/serial_line_model.sv
// Remote serial sender driving one receive line
module serial_line_model #(
    parameter int BAUD_DIV = 8
) (
    // Clock and line
    input  wire  ref_clk,
    output logic line
);
    timeunit 1ns;
    timeprecision 1ps;
    initial line = 1'b1;
    // Idle high, LSB first; bad parity only when the bench asks for it
    task automatic send(input logic [7:0] ch, input logic par_on, input logic par_bad);
        logic [10:0] f;
        f = par_on ? {1'b1, ^ch ^ par_bad, ch, 1'b0} : {2'b11, ch, 1'b0};
        for (int i = 0; i < 11; i++) begin
            @(posedge ref_clk);
            line <= f[i];
            repeat (BAUD_DIV - 1) @(posedge ref_clk);
        end
    endtask
endmodule

// ### verification/serial_char_rx_tb.sv
// Self-checking bench for the two-port character receive block
`include "serial_char_rx_map.vh"
module serial_char_rx_tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int BD = 8;
    logic        ref_clk = 0, nrst = 0, avs_read = 0, avs_write = 0;
    logic [5:0]  avs_address = 0;
    logic [31:0] avs_writedata = 0;
    logic [3:0]  avs_byteenable = 4'hf;
    wire  [31:0] avs_readdata;
    wire         avs_waitrequest, irq, rx0_pin, rx1_pin;
    logic [31:0] exp_q[$], mask_q[$];
    int          num_errors = 0, n_tests = 0;
    integer      seed = 32'h0f9a;
    logic [7:0]  ch;
    always #4 ref_clk = ~ref_clk;
    serial_char_rx #(.BAUD_DIV(BD)) u_dut (.ref_clk(ref_clk), .nrst(nrst), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .rx0_pin(rx0_pin), .rx1_pin(rx1_pin), .irq(irq));
    serial_line_model #(.BAUD_DIV(BD)) u_line0 (.ref_clk(ref_clk), .line(rx0_pin));
    serial_line_model #(.BAUD_DIV(BD)) u_line1 (.ref_clk(ref_clk), .line(rx1_pin));
    task automatic compare(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_tests++;
        if (got !== exp) begin
            num_errors++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic end_sim;
        $display("Comparisons %0d, mismatches %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    // Request held until waitrequest is seen low, then one idle edge
    task automatic bus(input logic wr, input logic [5:0] adr, input logic [31:0] d);
        int t;
        t = 0;
        avs_address <= adr;
        avs_writedata <= d;
        avs_write <= wr;
        avs_read <= !wr;
        do begin
            @(posedge ref_clk);
            t++;
        end while (avs_waitrequest !== 1'b0 && t < 50);
        if (t >= 50) begin
            num_errors++;
            end_sim();
        end
        avs_write <= 0;
        avs_read <= 0;
        @(posedge ref_clk);
    endtask
    task automatic rd(input logic [5:0] adr, input logic [31:0] e, input logic [31:0] m = '1);
        exp_q.push_back(e & m);
        mask_q.push_back(m);
        bus(0, adr, 0);
    endtask
    always @(posedge ref_clk) begin
        if (avs_read && avs_waitrequest === 1'b0 && exp_q.size() > 0)
            compare("readdata", exp_q.pop_front(), avs_readdata & mask_q.pop_front());
    end
    // Handler reads each character well within one character time
    task automatic rx_char(input logic p, input logic par_on, input logic bad, input logic en);
        ch = 8'($random(seed));
        if (p)
            u_line1.send(ch, par_on, bad);
        else
            u_line0.send(ch, par_on, bad);
        repeat (4) @(posedge ref_clk);
        compare("irq", en, irq);
        rd(`OFS_RX_CHAR_BUFFER, ch);
        rd(`OFS_RX_PARITY_STATUS, par_on & bad);
        rd(`OFS_LAST_EVENT, p ? 25 : 8);
        rd(`OFS_IRQ_STATUS, p ? 2 : 1);
        bus(1, `OFS_IRQ_CLEAR, 3);
        repeat (2) @(posedge ref_clk);
        compare("irq", 0, irq);
    endtask
    initial begin
        repeat (4) @(posedge ref_clk);
        nrst <= 1;
        @(posedge ref_clk);
        rd(`OFS_PORT_CONFIG, 32'h0000_0003);
        rd(`OFS_IRQ_ENABLE, 0);
        rd(6'h3C, 0);
        bus(1, `OFS_IRQ_ENABLE, 3);
        bus(1, `OFS_PORT_CONFIG, 32'h0000_000F);
        for (int k = 0; k < 4; k++)
            rx_char(k[0], 1, k[1], 1);
        // Both ports finish together: port 1 lands one cycle after port 0
        fork
            u_line0.send(8'hA5, 1, 0);
            u_line1.send(8'h3C, 1, 1);
        join
        repeat (4) @(posedge ref_clk);
        compare("irq", 1, irq);
        rd(`OFS_RX_CHAR_BUFFER, 32'h0000_003C);
        rd(`OFS_RX_PARITY_STATUS, 1);
        rd(`OFS_LAST_EVENT, 25);
        rd(`OFS_IRQ_STATUS, 3);
        bus(1, `OFS_IRQ_CLEAR, 3);
        repeat (2) @(posedge ref_clk);
        compare("irq", 0, irq);
        bus(1, `OFS_IRQ_ENABLE, 0);
        bus(1, `OFS_PORT_CONFIG, 32'h0000_0003);
        rx_char(1, 0, 0, 0);
        bus(1, `OFS_ADDR_CMD, 0);
        rd(`OFS_ADDR_RESULT, 32'h0000_0102);
        bus(1, `OFS_ADDR_CMD, 32'h0000_0355);
        bus(1, `OFS_ADDR_CMD, 32'h0000_0200);
        rd(`OFS_ADDR_RESULT, 32'h0000_0155);
        bus(1, `OFS_ADDR_CMD, 32'h0000_0400);
        rd(`OFS_ADDR_RESULT, 32'h0006_0000, 32'hFFFF_FF00);
        bus(1, `OFS_PORT_CONFIG, 32'h0000_0043);
        bus(1, `OFS_ADDR_CMD, 32'h0000_0377);
        rd(`OFS_ADDR_RESULT, 32'h0004_0000, 32'hFFFF_FF00);
        bus(1, `OFS_ADDR_CMD, 32'h0000_0200);
        rd(`OFS_ADDR_RESULT, 32'h0000_0155);
        nrst <= 0;
        repeat (2) @(posedge ref_clk);
        nrst <= 1;
        @(posedge ref_clk);
        bus(1, `OFS_ADDR_CMD, 32'h0000_0200);
        rd(`OFS_ADDR_RESULT, 32'h0000_0103);
        end_sim();
    end
    initial begin
        repeat (10000) @(posedge ref_clk);
        num_errors++;
        end_sim();
    end
endmodule
